// *** sso_pkg.sv ***
// ****************************************************************
// Package for the servo status output block
// ****************************************************************
package sso_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ = 100;
    localparam int POWERUP_MS = 1500;
    localparam int POWERUP_CYC = POWERUP_MS * 1000 * CLK_MHZ;
    localparam int ZPULSE_US = 400;
    localparam int ZPULSE_CYC = ZPULSE_US * CLK_MHZ;
    localparam int BRAKE_UNIT_US = 1000;
    localparam int BRAKE_UNIT_CYC = BRAKE_UNIT_US * CLK_MHZ;

    // ****************************************************************
    // Speed figures and widths
    // ****************************************************************
    localparam logic [15:0] SPD_ALWAYS_RPM = 16'h0014;
    localparam logic [15:0] ZERO_HYST_RPM = 16'h0014;
    localparam logic [15:0] ZERO_DEFAULT_RPM = 16'h0032;
    localparam logic [15:0] SPD_TOL_RPM = 16'h000a;
    localparam int MON_BITS = 10;

    // ****************************************************************
    // Register map, index, one 16-bit register per word
    // ****************************************************************
    localparam logic [3:0] REG_INPOS = 4'h0;
    localparam logic [3:0] REG_PPR = 4'h1;
    localparam logic [3:0] REG_BRAKE = 4'h2;
    localparam logic [3:0] REG_PHASE = 4'h3;
    localparam logic [3:0] REG_ZSPD = 4'h4;
    localparam logic [3:0] REG_MON1 = 4'h5;
    localparam logic [3:0] REG_MON2 = 4'h6;
    localparam logic [3:0] REG_ASSIGN = 4'h7;
    localparam logic [3:0] REG_STATUS = 4'h8;

    // Reset values.
    localparam logic [15:0] INPOS_RST = 16'h0064;
    localparam logic [15:0] PPR_RST = 16'h0fa0;
    localparam logic [15:0] BRAKE_RST = 16'h0000;
    localparam logic [15:0] ASSIGN_RST = 16'h0000;

    // Bit positions of the optional-output assignment mask.
    localparam int AS_RD = 0;
    localparam int AS_SPD = 1;
    localparam int AS_TRQ = 2;
    localparam int AS_ZERO = 3;
    localparam int AS_WARN = 4;
    localparam int AS_BW = 5;
    localparam int AS_GS = 6;
    localparam int AS_ABS = 7;

    // Monitor selections.
    localparam logic [1:0] MON_SPEED = 2'h0;
    localparam logic [1:0] MON_TORQUE = 2'h1;
    localparam logic [1:0] MON_DROOP = 2'h2;
    localparam logic [1:0] MON_CMD = 2'h3;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } sso_bus_t;

    typedef struct packed {
        logic servo_on;
        logic alarm;
        logic base_shutoff;
        logic able;
        logic warning;
        logic bat_cable_warn;
        logic bat_warn;
        logic gain_switch;
        logic abs_erased;
        logic speed_loop;
        logic torque_at_limit;
    } sso_cond_t;

    typedef struct packed {
        logic signed [15:0] speed_rpm;
        logic signed [15:0] cmd_rpm;
        logic signed [15:0] torque;
        logic signed [31:0] droop;
        logic [31:0] motor_pos;
        logic [31:0] pos_per_rev;
    } sso_meas_t;

    typedef struct packed {
        logic trouble_out;
        logic brake_interlock;
        logic in_position;
        logic ready;
        logic speed_reached;
        logic torque_limiting;
        logic zero_speed;
        logic warning_out;
        logic battery_warning;
        logic gain_switch_active;
        logic abs_position_lost;
    } sso_dout_t;

    typedef struct packed {
        logic enc_a_pos;
        logic enc_a_neg;
        logic enc_b_pos;
        logic enc_b_neg;
        logic enc_z_pos;
        logic enc_z_neg;
    } sso_enc_t;

endpackage

// *** sso_top.sv ***
`timescale 1ns/10ps
module sso_top #(
    parameter int POWERUP_CYCLES = sso_pkg::POWERUP_CYC
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Register port
    input wire sso_pkg::sso_bus_t bus_i,
    output logic [15:0] rdata_o,
    // Amplifier conditions, from pins
    input wire sso_pkg::sso_cond_t cond_i,
    // Measurements from the control loop, same clock
    input wire sso_pkg::sso_meas_t meas_i,
    // Outputs
    output sso_pkg::sso_dout_t dout_o,
    output sso_pkg::sso_enc_t enc_o,
    output logic [9:0] analog_mon_one_o,
    output logic [9:0] analog_mon_two_o
);
    import sso_pkg::*;

    function automatic logic [15:0] abs16(input logic signed [15:0] v);
        abs16 = v[15] ? 16'(-v) : 16'(v);
    endfunction

    function automatic logic [9:0] mon_pick(input logic [1:0] sel, input sso_meas_t m);
        logic [9:0] r;
        r = 10'h000;
        case (sel)
            MON_SPEED: r = m.speed_rpm[15:6];
            MON_TORQUE: r = m.torque[15:6];
            MON_DROOP: r = m.droop[15:6];
            default: r = m.cmd_rpm[15:6];
        endcase
        return r;
    endfunction

    typedef struct packed {
        sso_cond_t c1;
        sso_cond_t c2;
        logic [31:0] pwr_cnt;
        logic powered;
        logic [15:0] inpos_r;
        logic [15:0] ppr_r;
        logic [15:0] brake_r;
        logic phase_r;
        logic [15:0] zspd_r;
        logic [1:0] mon1_r;
        logic [1:0] mon2_r;
        logic [7:0] assign_r;
        logic [15:0] rdata;
        logic [31:0] brk_cnt;
        logic brk_on;
        logic zero_hit;
        logic abs_lost;
        logic [31:0] enc_acc;
        logic [1:0] quad;
        logic [31:0] last_pos;
        logic [31:0] z_cnt;
        sso_dout_t dout;
        sso_enc_t enc;
        logic [9:0] mon1;
        logic [9:0] mon2;
    } sso_state_t;

    sso_state_t st_r;
    sso_state_t st_nxt;

    logic [15:0] spd_abs;
    logic [15:0] cmd_abs;
    logic [15:0] err_abs;
    logic [31:0] dr_abs;
    logic [31:0] rev_pos;
    logic [31:0] last_rev;
    logic [31:0] step;
    logic [32:0] acc_sum;
    logic fwd;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        spd_abs = abs16(meas_i.speed_rpm);
        cmd_abs = abs16(meas_i.cmd_rpm);
        err_abs = abs16(16'(meas_i.speed_rpm - meas_i.cmd_rpm));
        dr_abs = meas_i.droop[31] ? 32'(-meas_i.droop) : 32'(meas_i.droop);
        rev_pos = (meas_i.pos_per_rev == 32'h0) ? 32'h0 : meas_i.motor_pos % meas_i.pos_per_rev;
        last_rev = (meas_i.pos_per_rev == 32'h0) ? 32'h0 : st_r.last_pos % meas_i.pos_per_rev;
        step = 32'h0;
        acc_sum = 33'h0;
        fwd = 1'b0;
        // Pin conditions are double-registered before use.
        st_nxt.c1 = cond_i;
        st_nxt.c2 = st_r.c1;
        // Register port.
        st_nxt.rdata = 16'h0000;
        if (bus_i.wr) begin
            if (bus_i.addr == REG_INPOS) begin
                st_nxt.inpos_r = bus_i.wdata;
            end else if (bus_i.addr == REG_PPR) begin
                st_nxt.ppr_r = bus_i.wdata;
            end else if (bus_i.addr == REG_BRAKE) begin
                st_nxt.brake_r = bus_i.wdata;
            end else if (bus_i.addr == REG_PHASE) begin
                st_nxt.phase_r = bus_i.wdata[0];
            end else if (bus_i.addr == REG_ZSPD) begin
                st_nxt.zspd_r = bus_i.wdata;
            end else if (bus_i.addr == REG_MON1) begin
                st_nxt.mon1_r = bus_i.wdata[1:0];
            end else if (bus_i.addr == REG_MON2) begin
                st_nxt.mon2_r = bus_i.wdata[1:0];
            end else if (bus_i.addr == REG_ASSIGN) begin
                st_nxt.assign_r = bus_i.wdata[7:0];
            end
        end
        if (bus_i.rd) begin
            if (bus_i.addr == REG_INPOS) begin
                st_nxt.rdata = st_r.inpos_r;
            end else if (bus_i.addr == REG_PPR) begin
                st_nxt.rdata = st_r.ppr_r;
            end else if (bus_i.addr == REG_BRAKE) begin
                st_nxt.rdata = st_r.brake_r;
            end else if (bus_i.addr == REG_PHASE) begin
                st_nxt.rdata = {15'h0000, st_r.phase_r};
            end else if (bus_i.addr == REG_ZSPD) begin
                st_nxt.rdata = st_r.zspd_r;
            end else if (bus_i.addr == REG_MON1) begin
                st_nxt.rdata = {14'h0000, st_r.mon1_r};
            end else if (bus_i.addr == REG_MON2) begin
                st_nxt.rdata = {14'h0000, st_r.mon2_r};
            end else if (bus_i.addr == REG_ASSIGN) begin
                st_nxt.rdata = {8'h00, st_r.assign_r};
            end else if (bus_i.addr == REG_STATUS) begin
                st_nxt.rdata = {5'h00, st_r.dout};
            end
        end
        // Power-up settle window; trouble, warning and battery outputs stay off until it ends.
        if (!st_r.powered) begin
            if (st_r.pwr_cnt >= 32'(POWERUP_CYCLES - 1)) begin
                st_nxt.powered = 1'b1;
            end else begin
                st_nxt.pwr_cnt = st_r.pwr_cnt + 32'h1;
            end
        end
        st_nxt.dout.trouble_out = st_r.powered && !st_r.c2.alarm
            && !st_r.c2.base_shutoff;
        // Brake interlock releases only after the set delay of servo on.
        if (!st_r.c2.servo_on || st_r.c2.alarm) begin
            st_nxt.brk_cnt = 32'h0;
            st_nxt.brk_on = 1'b0;
        end else if (st_r.brk_cnt >= 32'(st_r.brake_r) * 32'(BRAKE_UNIT_CYC)) begin
            st_nxt.brk_on = 1'b1;
        end else begin
            st_nxt.brk_cnt = st_r.brk_cnt + 32'h1;
        end
        st_nxt.dout.brake_interlock = st_r.brk_on && !st_r.c2.alarm && st_r.c2.servo_on;
        st_nxt.dout.in_position = st_r.c2.servo_on && !st_r.c2.speed_loop
            && (dr_abs <= 32'(st_r.inpos_r));
        st_nxt.dout.ready = st_r.assign_r[AS_RD] && st_r.c2.servo_on
            && st_r.c2.able;
        st_nxt.dout.speed_reached = st_r.assign_r[AS_SPD] && st_r.c2.servo_on
            && st_r.c2.speed_loop
            && ((cmd_abs <= SPD_ALWAYS_RPM) || (err_abs <= SPD_TOL_RPM));
        st_nxt.dout.torque_limiting = st_r.assign_r[AS_TRQ] && st_r.c2.servo_on
            && st_r.c2.torque_at_limit;
        // Turn on at the threshold, turn off only above threshold plus band.
        if (spd_abs <= st_r.zspd_r) begin
            st_nxt.zero_hit = 1'b1;
        end else if (spd_abs > 16'(st_r.zspd_r + ZERO_HYST_RPM)) begin
            st_nxt.zero_hit = 1'b0;
        end
        st_nxt.dout.zero_speed = st_r.assign_r[AS_ZERO] && st_r.zero_hit;
        st_nxt.dout.warning_out = st_r.assign_r[AS_WARN] && st_r.powered
            && st_r.c2.warning;
        st_nxt.dout.battery_warning = st_r.assign_r[AS_BW] && st_r.powered
            && (st_r.c2.bat_cable_warn || st_r.c2.bat_warn);
        st_nxt.dout.gain_switch_active = st_r.assign_r[AS_GS] && st_r.c2.gain_switch;
        if (st_r.c2.abs_erased) begin
            st_nxt.abs_lost = 1'b1;
        end
        st_nxt.dout.abs_position_lost = st_r.assign_r[AS_ABS] && st_r.abs_lost
            && st_r.c2.speed_loop;
        // Count down first so that a new revolution mark below reloads the pulse.
        if (st_r.z_cnt != 32'h0) begin
            st_nxt.z_cnt = st_r.z_cnt - 32'h1;
        end
        // Emulated encoder: one quadrature edge per scaled motor step.
        fwd = (meas_i.motor_pos != st_r.last_pos) && !(meas_i.motor_pos - st_r.last_pos > 32'h7fffffff);
        if (meas_i.motor_pos != st_r.last_pos && meas_i.pos_per_rev != 32'h0) begin
            step = 32'(st_r.ppr_r) << 2;
            acc_sum = {1'b0, st_r.enc_acc} + {1'b0, step};
            if (acc_sum >= {1'b0, meas_i.pos_per_rev}) begin
                st_nxt.enc_acc = 32'(acc_sum - {1'b0, meas_i.pos_per_rev});
                // CCW advances A ahead of B; the parameter swaps the order.
                if (fwd ^ st_r.phase_r) begin
                    st_nxt.quad = {~st_r.quad[0], st_r.quad[1]};
                end else begin
                    st_nxt.quad = {st_r.quad[0], ~st_r.quad[1]};
                end
            end else begin
                st_nxt.enc_acc = acc_sum[31:0];
            end
            if (rev_pos < last_rev && fwd || rev_pos > last_rev && !fwd) begin
                st_nxt.z_cnt = 32'(ZPULSE_CYC);
            end
        end
        st_nxt.last_pos = meas_i.motor_pos;
        st_nxt.enc.enc_a_pos = st_r.quad[1];
        st_nxt.enc.enc_a_neg = ~st_r.quad[1];
        st_nxt.enc.enc_b_pos = st_r.quad[0];
        st_nxt.enc.enc_b_neg = ~st_r.quad[0];
        st_nxt.enc.enc_z_pos = st_r.z_cnt != 32'h0;
        st_nxt.enc.enc_z_neg = st_r.z_cnt == 32'h0;
        st_nxt.mon1 = mon_pick(st_r.mon1_r, meas_i);
        st_nxt.mon2 = mon_pick(st_r.mon2_r, meas_i);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
            st_r.inpos_r <= INPOS_RST;
            st_r.ppr_r <= PPR_RST;
            st_r.brake_r <= BRAKE_RST;
            st_r.zspd_r <= ZERO_DEFAULT_RPM;
            st_r.assign_r <= ASSIGN_RST[7:0];
            st_r.enc.enc_a_neg <= 1'b1;
            st_r.enc.enc_b_neg <= 1'b1;
            st_r.enc.enc_z_neg <= 1'b1;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o = st_r.rdata;
    assign dout_o = st_r.dout;
    assign enc_o = st_r.enc;
    assign analog_mon_one_o = st_r.mon1;
    assign analog_mon_two_o = st_r.mon2;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_trouble_alarm: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && st_r.c2.alarm |=> !dout_o.trouble_out)
        else $error("trouble output on during alarm");
    a_brake_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && !st_r.c2.servo_on |=> !dout_o.brake_interlock)
        else $error("brake interlock on while servo off");
    a_inpos_speed: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && st_r.c2.speed_loop |=> !dout_o.in_position)
        else $error("in-position in speed loop");
    a_ready_cond: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && !(st_r.c2.servo_on && st_r.c2.able) |=> !dout_o.ready)
        else $error("ready without servo on and able");
    a_spd_servo_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && !st_r.c2.servo_on |=> !dout_o.speed_reached)
        else $error("speed reached while servo off");
    a_trq_servo_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && !st_r.c2.servo_on |=> !dout_o.torque_limiting)
        else $error("torque limiting while servo off");
    a_zero_hyst: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && st_r.zero_hit && spd_abs <= 16'(st_r.zspd_r + ZERO_HYST_RPM)
        |=> st_r.zero_hit)
        else $error("zero speed dropped inside hysteresis band");
    a_abs_sticky: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        st_r.abs_lost |=> st_r.abs_lost)
        else $error("absolute position lost flag cleared");
    a_zpulse_width: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && $rose(enc_o.enc_z_pos) |-> st_r.z_cnt >= 32'(ZPULSE_CYC - 2))
        else $error("zero pulse too short");
endmodule

// *** sso_enc_watch.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Receiver of the emulated encoder lines
// ****************************************************************
module sso_enc_watch (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Encoder lines
    input wire sso_pkg::sso_enc_t enc_i,
    // Counts, levels and pair checks seen on the lines
    output int a_rise_o,
    output logic b_at_a_o,
    output int z_count_o,
    output int z_width_o,
    output logic pair_bad_o
);
    import sso_pkg::*;
    int z_len;
    sso_enc_t last;
    // A receiver only listens, so it judges each line on the clock edge it shares.
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            a_rise_o <= 0;
            b_at_a_o <= 1'b0;
            z_count_o <= 0;
            z_width_o <= 0;
            pair_bad_o <= 1'b0;
            z_len <= 0;
            last <= enc_i;
        end else begin
            last <= enc_i;
            if (enc_i.enc_a_pos && !last.enc_a_pos) begin
                a_rise_o <= a_rise_o + 1;
                b_at_a_o <= enc_i.enc_b_pos;
            end
            if (enc_i.enc_z_pos && !last.enc_z_pos) begin
                z_count_o <= z_count_o + 1;
            end
            z_len <= enc_i.enc_z_pos ? z_len + 1 : 0;
            if (!enc_i.enc_z_pos && last.enc_z_pos) begin
                z_width_o <= z_len;
            end
            if (enc_i.enc_a_neg == enc_i.enc_a_pos || enc_i.enc_b_neg == enc_i.enc_b_pos ||
                enc_i.enc_z_neg == enc_i.enc_z_pos) begin
                pair_bad_o <= 1'b1;
            end
        end
    end
endmodule

// *** sso_top_tb.sv ***
`timescale 1ns/10ps
module sso_top_tb;
    import sso_pkg::*;
    logic clock_i;
    logic rst_n_i;
    logic clk_en;
    sso_bus_t bus;
    logic [15:0] rdata;
    sso_cond_t cond;
    sso_meas_t meas;
    sso_dout_t dout;
    sso_enc_t enc;
    logic [9:0] mon1;
    logic [9:0] mon2;
    int a_rise;
    logic b_at_a;
    int z_count;
    int z_width;
    logic pair_bad;
    int err_count;
    int cmp_count;
    int cyc;
    int a0;

    // ****************************************************************
    // Design and encoder receiver
    // ****************************************************************
    sso_top #(.POWERUP_CYCLES(20)) i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .clk_en_i(clk_en), .bus_i(bus), .rdata_o(rdata), .cond_i(cond), .meas_i(meas),
        .dout_o(dout), .enc_o(enc), .analog_mon_one_o(mon1), .analog_mon_two_o(mon2));
    sso_enc_watch i_watch (.clock_i(clock_i), .rst_n_i(rst_n_i), .enc_i(enc),
        .a_rise_o(a_rise), .b_at_a_o(b_at_a), .z_count_o(z_count), .z_width_o(z_width),
        .pair_bad_o(pair_bad));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic final_report;
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        bus.wr <= 1'b0;
    endtask
    task automatic rd_chk(input string name, input logic [3:0] a, input logic [15:0] e);
        @(posedge clock_i);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        bus.rd <= 1'b0;
        #1;
        chk(name, 32'(e), 32'(rdata));
    endtask
    // Conditions pass two synchronisers and the output stage, so four edges suffice.
    task automatic settle;
        repeat (4) @(posedge clock_i);
        #1;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs;
        rd_chk("inpos", REG_INPOS, 16'h0064);
        rd_chk("ppr", REG_PPR, 16'h0fa0);
        rd_chk("brake", REG_BRAKE, 16'h0000);
        rd_chk("zspd", REG_ZSPD, 16'h0032);
        rd_chk("assign", REG_ASSIGN, 16'h0000);
        wr(4'hf, 16'h1234);
        rd_chk("unmapped", 4'hf, 16'h0000);
    endtask
    task automatic t_brake;
        wr(REG_BRAKE, 16'h0001);
        @(posedge clock_i);
        cond.servo_on <= 1'b1;
        cond.able <= 1'b1;
        repeat (100) @(posedge clock_i);
        #1;
        chk("brake delayed", 0, dout.brake_interlock);
        wr(REG_BRAKE, 16'h0000);
        settle;
        chk("brake on", 1, dout.brake_interlock);
        chk("ready unassigned", 0, dout.ready);
        wr(REG_ASSIGN, 16'h00ff);
        settle;
        chk("ready", 1, dout.ready);
        @(posedge clock_i);
        cond.able <= 1'b0;
        cond.alarm <= 1'b1;
        settle;
        chk("ready unable", 0, dout.ready);
        chk("brake alarm", 0, dout.brake_interlock);
        @(posedge clock_i);
        cond.able <= 1'b1;
        cond.alarm <= 1'b0;
        cond.base_shutoff <= 1'b1;
        settle;
        chk("trouble shutoff", 0, dout.trouble_out);
        @(posedge clock_i);
        cond.base_shutoff <= 1'b0;
        cond.servo_on <= 1'b0;
        settle;
        chk("brake servo off", 0, dout.brake_interlock);
        chk("trouble back", 1, dout.trouble_out);
        rd_chk("status", REG_STATUS, 16'h0410);
    endtask
    task automatic t_inpos;
        int dr[3] = '{100, 101, -100};
        logic ex[3] = '{1'b1, 1'b0, 1'b1};
        @(posedge clock_i);
        cond.servo_on <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(posedge clock_i);
            meas.droop <= dr[i];
            settle;
            chk("inpos", 32'(ex[i]), dout.in_position);
        end
        @(posedge clock_i);
        cond.speed_loop <= 1'b1;
        settle;
        chk("inpos speed loop", 0, dout.in_position);
    endtask
    task automatic t_speed;
        int sp[3] = '{1010, 1011, 1011};
        int cm[3] = '{1000, 1000, 20};
        logic ex[3] = '{1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 3; i++) begin
            @(posedge clock_i);
            meas.speed_rpm <= 16'(sp[i]);
            meas.cmd_rpm <= 16'(cm[i]);
            settle;
            chk("speed reached", 32'(ex[i]), dout.speed_reached);
        end
        @(posedge clock_i);
        cond.torque_at_limit <= 1'b1;
        settle;
        chk("torque limit", 1, dout.torque_limiting);
        @(posedge clock_i);
        cond.servo_on <= 1'b0;
        settle;
        chk("spd servo off", 0, dout.speed_reached);
        chk("trq servo off", 0, dout.torque_limiting);
        @(posedge clock_i);
        cond.servo_on <= 1'b1;
        cond.speed_loop <= 1'b0;
        settle;
        chk("spd pos loop", 0, dout.speed_reached);
    endtask
    task automatic t_zero;
        int sp[7] = '{50, 70, 71, 51, 50, 51, 30};
        logic ex[7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 7; i++) begin
            if (i == 5) begin
                wr(REG_ZSPD, 16'h001e);
            end
            @(posedge clock_i);
            meas.speed_rpm <= 16'(sp[i]);
            settle;
            chk("zero speed", 32'(ex[i]), dout.zero_speed);
        end
    endtask
    task automatic t_flags;
        @(posedge clock_i);
        cond.speed_loop <= 1'b1;
        cond.warning <= 1'b1;
        cond.bat_cable_warn <= 1'b1;
        cond.gain_switch <= 1'b1;
        cond.abs_erased <= 1'b1;
        settle;
        chk("warning", 1, dout.warning_out);
        chk("bat cable", 1, dout.battery_warning);
        chk("gain", 1, dout.gain_switch_active);
        chk("abs lost", 1, dout.abs_position_lost);
        @(posedge clock_i);
        cond.warning <= 1'b0;
        cond.bat_cable_warn <= 1'b0;
        cond.bat_warn <= 1'b1;
        cond.gain_switch <= 1'b0;
        cond.abs_erased <= 1'b0;
        settle;
        chk("warning off", 0, dout.warning_out);
        chk("bat warn", 1, dout.battery_warning);
        chk("gain off", 0, dout.gain_switch_active);
        chk("abs held", 1, dout.abs_position_lost);
        wr(REG_ASSIGN, 16'h0000);
        settle;
        chk("bat unassigned", 0, dout.battery_warning);
    endtask
    task automatic t_mon;
        logic [9:0] ex[4] = '{10'h100, 10'h049, 10'h032, 10'h1ff};
        @(posedge clock_i);
        meas.speed_rpm <= 16'h4000;
        meas.torque <= 16'h1240;
        meas.droop <= 32'h0000_0c80;
        meas.cmd_rpm <= 16'h7fc0;
        for (int i = 0; i < 4; i++) begin
            wr(REG_MON1, 16'(i));
            wr(REG_MON2, 16'(3 - i));
            settle;
            chk("mon one", 32'(ex[i]), 32'(mon1));
            chk("mon two", 32'(ex[3 - i]), 32'(mon2));
        end
        // With the enable low a write must be lost and the monitor must hold.
        @(posedge clock_i);
        clk_en <= 1'b0;
        wr(REG_MON1, 16'h0000);
        settle;
        chk("mon one frozen", 32'(ex[3]), 32'(mon1));
        @(posedge clock_i);
        clk_en <= 1'b1;
        rd_chk("mon sel kept", REG_MON1, 16'h0003);
    endtask
    task automatic t_enc;
        wr(REG_PPR, 16'h0004);
        settle;
        a0 = a_rise;
        for (int i = 1; i <= 64; i++) begin
            @(posedge clock_i);
            meas.motor_pos <= 32'(i);
        end
        settle;
        chk("a pulses", 4, a_rise - a0);
        chk("b lags a", 0, b_at_a);
        repeat (40100) @(posedge clock_i);
        #1;
        chk("z count", 1, z_count);
        chk("z width", 1, z_width >= ZPULSE_CYC);
        wr(REG_PHASE, 16'h0001);
        settle;
        a0 = a_rise;
        for (int i = 65; i <= 96; i++) begin
            @(posedge clock_i);
            meas.motor_pos <= 32'(i);
        end
        settle;
        chk("a pulses inv", 2, a_rise - a0);
        chk("b leads a", 1, b_at_a);
        chk("diff pairs", 0, pair_bad);
    endtask

    // ****************************************************************
    // Clock, timeout and main sequence
    // ****************************************************************
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            final_report;
        end
    end
    initial begin
        rst_n_i = 1'b0;
        clk_en = 1'b1;
        bus = '0;
        cond = '0;
        meas = '0;
        meas.pos_per_rev = 32'h0000_0040;
        repeat (4) @(posedge clock_i);
        #1;
        chk("dout in reset", 32'h0, 32'(dout));
        chk("enc in reset", 32'h15, 32'(enc));
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        chk("trouble early", 0, dout.trouble_out);
        repeat (30) @(posedge clock_i);
        #1;
        chk("trouble late", 1, dout.trouble_out);
        t_regs();
        t_brake();
        t_inpos();
        t_speed();
        t_zero();
        t_flags();
        t_mon();
        t_enc();
        final_report();
    end
endmodule
